// *** rtl/csbx_pkg.sv ***
// Purpose: Shared types and constants for the compare, skip and flag-branch executor
// Assumes: 16-bit program counter counted in words, 8-bit working registers
// Notes: Register map is a small set of control and status words on AHB-Lite
package csbx_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CSBX_OFS_INSTR = 8'h00;
   localparam logic [7:0] CSBX_OFS_OPERANDS = 8'h04;
   localparam logic [7:0] CSBX_OFS_PC = 8'h08;
   localparam logic [7:0] CSBX_OFS_STATUS = 8'h0c;
   localparam logic [7:0] CSBX_OFS_ENGINE = 8'h10;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CSBX_INSTR_OP_LSB = 0;
   localparam int CSBX_INSTR_BIT_LSB = 4;
   localparam int CSBX_INSTR_NEXT2_POS = 7;
   localparam int CSBX_INSTR_OFS_LSB = 8;
   localparam int CSBX_INSTR_GO_POS = 31;
   localparam int CSBX_OPS_A_LSB = 0;
   localparam int CSBX_OPS_B_LSB = 8;
   localparam int CSBX_OPS_IO_LSB = 16;
   localparam int CSBX_FLAG_C = 0;
   localparam int CSBX_FLAG_Z = 1;
   localparam int CSBX_FLAG_N = 2;
   localparam int CSBX_FLAG_V = 3;
   localparam int CSBX_FLAG_S = 4;
   localparam int CSBX_FLAG_H = 5;

   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic [15:0] CSBX_PC_RESET = 16'h0000;
   localparam logic [7:0] CSBX_STATUS_REGISTER_RESET = 8'h00;
   localparam logic [1:0] CSBX_ONE_CYCLE = 2'h1;
   localparam logic [15:0] CSBX_PC_STEP = 16'h0001;
   localparam logic [15:0] CSBX_SKIP_ONE = 16'h0002;
   localparam logic [15:0] CSBX_SKIP_TWO = 16'h0003;
   localparam logic [31:0] CSBX_UNMAPPED = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Operations
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      compare_skip_equal_op = 4'h0,
      compare_regs_op = 4'h1,
      compare_with_carry_op = 4'h2,
      compare_immediate_op = 4'h3,
      skip_reg_bit_clear_op = 4'h4,
      skip_reg_bit_set_op = 4'h5,
      skip_io_bit_clear_op = 4'h6,
      skip_io_bit_set_op = 4'h7,
      branch_flag_set_op = 4'h8,
      branch_flag_clear_op = 4'h9
   } csbx_op_t;

   typedef enum logic [1:0] {
      CSBX_IDLE = 2'b00,
      CSBX_EXTRA = 2'b01
   } csbx_state_t;

   // Decoded instruction as handed to the executor
   typedef struct packed {
      csbx_op_t op;
      logic [2:0] bit_sel;
      logic next_is_two;
      logic [6:0] offset;
      logic [7:0] opnd_a;
      logic [7:0] opnd_b;
      logic [7:0] io_value;
   } csbx_instr_t;

   // Executor result
   typedef struct packed {
      logic [15:0] pc;
      logic [7:0] status_register;
      logic [1:0] cycles;
      logic busy;
      logic done;
   } csbx_result_t;

endpackage

// *** rtl/csbx_core.sv ***
// Purpose: Executes one compare, skip or flag-branch instruction on the program counter
// Assumes: Operands are already fetched; instruction held stable while busy
// Notes: Extra cycles of a skip or taken branch are spent in state CSBX_EXTRA
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
module csbx_core
   import csbx_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Instruction
   input wire logic start,
   input wire csbx_instr_t instr,
   // Architectural state in
   input wire logic [15:0] pc_in,
   input wire logic [7:0] status_register_in,
   // Result
   output csbx_result_t result
);

   typedef struct packed {
      csbx_state_t state;
      logic [1:0] left;
      csbx_result_t res;
   } csbx_core_state_t;

   csbx_core_state_t st;
   csbx_core_state_t next_st;

   // Subtract with flags; carry-in used by the carry-including compare
   function automatic logic [7:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin, input logic zin,
                                            input logic chain, input logic [7:0] s0);
      logic [7:0] d;
      logic [7:0] s;
      d = a - b - {7'h00, cin};
      s = s0;
      s[CSBX_FLAG_H] = (~a[3] & b[3]) | (b[3] & d[3]) | (d[3] & ~a[3]);
      s[CSBX_FLAG_C] = (~a[7] & b[7]) | (b[7] & d[7]) | (d[7] & ~a[7]);
      s[CSBX_FLAG_V] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
      s[CSBX_FLAG_N] = d[7];
      // Carry-including form keeps Z only if it was already set
      s[CSBX_FLAG_Z] = (d == 8'h00) & (chain ? zin : 1'b1);
      s[CSBX_FLAG_S] = d[7] ^ s[CSBX_FLAG_V];
      return s;
   endfunction

   always_comb begin
      logic skip;
      logic taken;
      logic fl;
      skip = 1'b0;
      taken = 1'b0;
      fl = status_register_in[instr.bit_sel];
      next_st = st;
      next_st.res.done = 1'b0;
      unique case (st.state)
         CSBX_IDLE: begin
            if (start) begin
               next_st.res.status_register = status_register_in;
               next_st.res.pc = pc_in + CSBX_PC_STEP;
               unique case (instr.op)
                  compare_skip_equal_op: skip = (instr.opnd_a == instr.opnd_b);
                  compare_regs_op: next_st.res.status_register = sub_flags(instr.opnd_a, instr.opnd_b,
                     1'b0, 1'b0, 1'b0, status_register_in);
                  compare_with_carry_op: next_st.res.status_register = sub_flags(instr.opnd_a,
                     instr.opnd_b, status_register_in[CSBX_FLAG_C], status_register_in[CSBX_FLAG_Z], 1'b1,
                     status_register_in);
                  compare_immediate_op: next_st.res.status_register = sub_flags(instr.opnd_a,
                     instr.opnd_b, 1'b0, 1'b0, 1'b0, status_register_in);
                  skip_reg_bit_clear_op: skip = ~instr.opnd_a[instr.bit_sel];
                  skip_reg_bit_set_op: skip = instr.opnd_a[instr.bit_sel];
                  skip_io_bit_clear_op: skip = ~instr.io_value[instr.bit_sel];
                  skip_io_bit_set_op: skip = instr.io_value[instr.bit_sel];
                  branch_flag_set_op: taken = fl;
                  branch_flag_clear_op: taken = ~fl;
                  default: ;
               endcase
               if (skip) begin
                  // Skip: pc + 2 over one word, pc + 3 over a two-word instruction
                  next_st.res.pc = pc_in + (instr.next_is_two ? CSBX_SKIP_TWO : CSBX_SKIP_ONE);
                  next_st.left = instr.next_is_two ? 2'h2 : 2'h1;
                  next_st.res.cycles = instr.next_is_two ? 2'h3 : 2'h2;
               end else if (taken) begin
                  next_st.res.pc = pc_in + {{9{instr.offset[6]}}, instr.offset}
                     + CSBX_PC_STEP;
                  next_st.left = 2'h1;
                  next_st.res.cycles = 2'h2;
               end else begin
                  next_st.left = 2'h0;
                  next_st.res.cycles = CSBX_ONE_CYCLE;
               end
               if (skip || taken) begin
                  next_st.state = CSBX_EXTRA;
                  next_st.res.busy = 1'b1;
               end else begin
                  next_st.res.done = 1'b1;
               end
            end
         end
         CSBX_EXTRA: begin
            next_st.left = st.left - 2'h1;
            if (st.left == 2'h1) begin
               next_st.state = CSBX_IDLE;
               next_st.res.busy = 1'b0;
               next_st.res.done = 1'b1;
            end
         end
         default: next_st.state = CSBX_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st <= '{state: CSBX_IDLE, left: 2'h0,
                 res: '{pc: CSBX_PC_RESET, status_register: CSBX_STATUS_REGISTER_RESET, cycles: 2'h0,
                        busy: 1'b0, done: 1'b0}};
      end else begin
         st <= next_st;
      end
   end

   assign result = st.res;

endmodule

// *** rtl/csbx_top.sv ***
// Function
// - Compare-skip-equal skips next instruction when registers match; 1, 2 or 3 cycles.
// - Compare-immediate subtracts constant, keeps no result, sets Z N V C H S, one cycle.
// - Skip-reg-bit-clear skips when selected register bit is zero; flags unchanged.
// - Skip-io-bit-clear skips when selected I/O bit is zero; one to three cycles.
// - Skip-io-bit-set skips when selected I/O bit is one; flags unchanged.
// - Branch-flag-set loads pc plus offset plus one when flag is one; 1 or 2.
// - Branch-flag-clear branches when selected flag is zero; flags unchanged; 1 or 2.
//
// Purpose: AHB-Lite shell around the compare, skip and flag-branch executor
// Assumes: Single word transfers, zero wait states, OKAY responses only
// Notes: Writing the instruction word with its go bit set starts execution
`timescale 1ns/100ps
module csbx_top
   import csbx_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] instr_word;
      logic [31:0] ops_word;
      logic [15:0] pc;
      logic [7:0] status_register;
      logic start;
      logic [31:0] rdata;
   } csbx_top_state_t;

   csbx_top_state_t st;
   csbx_top_state_t next_st;
   csbx_result_t res;
   csbx_instr_t instr;

   function automatic logic [31:0] read_mux(input logic [7:0] a, input csbx_top_state_t s,
                                            input csbx_result_t r);
      logic [31:0] v;
      v = CSBX_UNMAPPED;
      unique case (a)
         CSBX_OFS_INSTR: v = {1'b0, s.instr_word[30:0]};
         CSBX_OFS_OPERANDS: v = s.ops_word;
         CSBX_OFS_PC: v = {16'h0000, s.pc};
         CSBX_OFS_STATUS: v = {24'h000000, s.status_register};
         CSBX_OFS_ENGINE: v = {28'h0000000, r.cycles, r.done, r.busy};
         default: v = CSBX_UNMAPPED;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // Instruction decode from registers
   // ----------------------------------------------------------------
   always_comb begin
      instr.op = csbx_op_t'(st.instr_word[CSBX_INSTR_OP_LSB +: 4]);
      instr.bit_sel = st.instr_word[CSBX_INSTR_BIT_LSB +: 3];
      instr.next_is_two = st.instr_word[CSBX_INSTR_NEXT2_POS];
      instr.offset = st.instr_word[CSBX_INSTR_OFS_LSB +: 7];
      instr.opnd_a = st.ops_word[CSBX_OPS_A_LSB +: 8];
      instr.opnd_b = st.ops_word[CSBX_OPS_B_LSB +: 8];
      instr.io_value = st.ops_word[CSBX_OPS_IO_LSB +: 8];
   end

   csbx_core u_core (
      .clock(clock),
      .arst_n(arst_n),
      .start(st.start),
      .instr(instr),
      .pc_in(st.pc),
      .status_register_in(st.status_register),
      .result(res)
   );

   // ----------------------------------------------------------------
   // Bus and architectural state
   // ----------------------------------------------------------------
   always_comb begin
      logic take;
      take = hsel && hready && htrans[1];
      next_st = st;
      next_st.start = 1'b0;
      next_st.wr_pend = take && hwrite;
      if (take) begin
         next_st.wr_addr = haddr[7:0];
      end
      if (take && !hwrite) begin
         next_st.rdata = read_mux(haddr[7:0], st, res);
      end
      // Executor results land when it reports done
      if (res.done) begin
         next_st.pc = res.pc;
         next_st.status_register = res.status_register;
      end
      // Software writes are ignored while the executor is busy on pc and flags
      if (st.wr_pend && !res.busy && !st.start) begin
         unique case (st.wr_addr)
            CSBX_OFS_INSTR: begin
               next_st.instr_word = hwdata;
               next_st.start = hwdata[CSBX_INSTR_GO_POS];
            end
            CSBX_OFS_OPERANDS: next_st.ops_word = hwdata;
            CSBX_OFS_PC: next_st.pc = hwdata[15:0];
            CSBX_OFS_STATUS: next_st.status_register = hwdata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st <= '{wr_pend: 1'b0, wr_addr: 8'h00, instr_word: 32'h0000_0000,
                 ops_word: 32'h0000_0000, pc: CSBX_PC_RESET, status_register: CSBX_STATUS_REGISTER_RESET,
                 start: 1'b0, rdata: 32'h0000_0000};
      end else begin
         st <= next_st;
      end
   end

   assign hrdata = st.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

endmodule

// *** test/csbx_monitor.sv ***
// Purpose: Bus-side checks on the compare, skip and flag-branch shell
// Assumes: Zero wait states; read data stands in the data phase
// Notes: Read data phase is tracked locally to judge hrdata
`timescale 1ns/100ps
module csbx_monitor
   import csbx_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // AHB-Lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp
);
   // ----------------------------------------------------------------
   // Data phase tracking
   // ----------------------------------------------------------------
   logic rd_ph;
   logic [7:0] rd_a;
   logic rd_take;
   assign rd_take = hsel && hready && htrans[1] && !hwrite;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rd_ph <= 1'b0;
         rd_a <= 8'h00;
      end else if (hready) begin
         rd_ph <= rd_take;
         rd_a <= haddr[7:0];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   ok_resp_a: assert property (hresp == 1'b0) else $error("response not OKAY");
   zero_wait_a: assert property (hreadyout == 1'b1) else $error("wait state inserted");
   go_reads_zero_a:
      assert property (rd_ph && rd_a == CSBX_OFS_INSTR |-> hrdata[31] == 1'b0)
         else $error("go bit read back set");
   pc_width_a:
      assert property (rd_ph && rd_a == CSBX_OFS_PC |-> hrdata[31:16] == 16'h0000)
         else $error("program counter wider than 16 bits");
   status_width_a:
      assert property (rd_ph && rd_a == CSBX_OFS_STATUS |-> hrdata[31:8] == 24'h000000)
         else $error("status wider than 8 bits");
   engine_width_a:
      assert property (rd_ph && rd_a == CSBX_OFS_ENGINE |-> hrdata[31:4] == 28'h0000000)
         else $error("engine word has stray bits");
   unmapped_read_a: assert property (rd_ph && rd_a > CSBX_OFS_ENGINE |-> hrdata == CSBX_UNMAPPED)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!rd_take |=> $stable(hrdata))
      else $error("read data moved without a read");
   engine_read_c: cover property (rd_ph && rd_a == CSBX_OFS_ENGINE && hrdata[0]);
   pc_read_c: cover property (rd_ph && rd_a == CSBX_OFS_PC);
   unmapped_c: cover property (rd_ph && rd_a > CSBX_OFS_ENGINE);
endmodule
bind csbx_top csbx_monitor mon (.clock, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
   .hwdata, .hready, .hrdata, .hreadyout, .hresp);

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the compare, skip and flag-branch shell
// Assumes: Zero wait slave, but every wait is polled
// Notes: Each row starts from pc 0x10
`timescale 1ns/100ps
module testbench
   import csbx_pkg::*;
;
   typedef struct packed {
      logic [3:0] op;
      logic [2:0] bs;
      logic n2;
      logic [6:0] k;
      logic [7:0] a, b, io, sr, epc, esr;
      logic [1:0] cyc;
   } csbx_row_t;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] q;
   int n_errors = 0;
   int check_count = 0;
   int n;
   csbx_row_t r;
   csbx_row_t rows [20] = '{
      '{4'h0, 3'h0, 1'h0, 7'h00, 8'h05, 8'h05, 8'h00, 8'h00, 8'h12, 8'h00, 2'h2},
      '{4'h0, 3'h0, 1'h1, 7'h00, 8'h05, 8'h05, 8'h00, 8'h00, 8'h13, 8'h00, 2'h3},
      '{4'h0, 3'h0, 1'h0, 7'h00, 8'h05, 8'h06, 8'h00, 8'h00, 8'h11, 8'h00, 2'h1},
      '{4'h1, 3'h0, 1'h0, 7'h00, 8'h10, 8'h10, 8'h00, 8'hc0, 8'h11, 8'hc2, 2'h1},
      '{4'h1, 3'h0, 1'h0, 7'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h11, 8'h35, 2'h1},
      '{4'h2, 3'h0, 1'h0, 7'h00, 8'h10, 8'h10, 8'h00, 8'h01, 8'h11, 8'h35, 2'h1},
      '{4'h2, 3'h0, 1'h0, 7'h00, 8'h10, 8'h10, 8'h00, 8'h00, 8'h11, 8'h00, 2'h1},
      '{4'h3, 3'h0, 1'h0, 7'h00, 8'h80, 8'h01, 8'h00, 8'h00, 8'h11, 8'h38, 2'h1},
      '{4'h4, 3'h3, 1'h0, 7'h00, 8'hf7, 8'h00, 8'h00, 8'h3f, 8'h12, 8'h3f, 2'h2},
      '{4'h4, 3'h3, 1'h0, 7'h00, 8'h08, 8'h00, 8'h00, 8'h3f, 8'h11, 8'h3f, 2'h1},
      '{4'h5, 3'h7, 1'h1, 7'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h13, 8'h00, 2'h3},
      '{4'h6, 3'h0, 1'h1, 7'h00, 8'h00, 8'h00, 8'hfe, 8'h00, 8'h13, 8'h00, 2'h3},
      '{4'h6, 3'h0, 1'h0, 7'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h11, 8'h00, 2'h1},
      '{4'h7, 3'h6, 1'h0, 7'h00, 8'h00, 8'h00, 8'h40, 8'h15, 8'h12, 8'h15, 2'h2},
      '{4'h7, 3'h6, 1'h0, 7'h00, 8'h00, 8'h00, 8'hbf, 8'h15, 8'h11, 8'h15, 2'h1},
      '{4'h8, 3'h1, 1'h0, 7'h05, 8'h00, 8'h00, 8'h00, 8'h02, 8'h16, 8'h02, 2'h2},
      '{4'h8, 3'h1, 1'h0, 7'h7d, 8'h00, 8'h00, 8'h00, 8'h02, 8'h0e, 8'h02, 2'h2},
      '{4'h8, 3'h1, 1'h0, 7'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 2'h1},
      '{4'h9, 3'h0, 1'h0, 7'h3f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h00, 2'h2},
      '{4'h9, 3'h0, 1'h0, 7'h3f, 8'h00, 8'h00, 8'h00, 8'h01, 8'h11, 8'h01, 2'h1}};

   csbx_top dut (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

   initial begin
      forever #5 clock = ~clock;
   end
   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int w;
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      w = 0;
      do begin @(posedge clock); w++; end while (hreadyout !== 1'b1 && w < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      w = 0;
      do begin @(posedge clock); w++; end while (hreadyout !== 1'b1 && w < 50);
      q = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic final_report();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      #200000;
      n_errors++;
      final_report();
   end
   initial begin
      repeat (20) @(posedge clock);
      chk(hrdata, 32'h0, "read data in reset");
      arst_n <= 1'b1;
      bus(0, CSBX_OFS_PC, 32'h0);
      chk(q, 32'h0, "pc reset");
      bus(0, CSBX_OFS_STATUS, 32'h0);
      chk(q, 32'h0, "status reset");
      foreach (rows[i]) begin
         r = rows[i];
         bus(1, CSBX_OFS_PC, 32'h10);
         bus(1, CSBX_OFS_STATUS, {24'h0, r.sr});
         bus(1, CSBX_OFS_OPERANDS, {8'h00, r.io, r.b, r.a});
         bus(1, CSBX_OFS_INSTR, {1'b1, 16'h0, r.k, r.n2, r.bs, r.op});
         n = 0;
         do begin bus(0, CSBX_OFS_ENGINE, 32'h0); n++; end while (q[0] !== 1'b0 && n < 20);
         bus(0, CSBX_OFS_ENGINE, 32'h0);
         chk({30'h0, q[3:2]}, {30'h0, r.cyc}, "cycles");
         bus(0, CSBX_OFS_PC, 32'h0);
         chk(q, {24'h0, r.epc}, "pc");
         bus(0, CSBX_OFS_STATUS, 32'h0);
         chk(q, {24'h0, r.esr}, "status");
      end
      bus(0, CSBX_OFS_INSTR, 32'h0);
      chk(q[31], 1'b0, "go bit reads back");
      bus(1, 8'h20, 32'hffff_ffff);
      bus(0, 8'h20, 32'h0);
      chk(q, CSBX_UNMAPPED, "unmapped read");
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      bus(0, CSBX_OFS_PC, 32'h0);
      chk(q, 32'h0, "pc after second reset");
      final_report();
   end
endmodule
